// [design/buf_regs_pkg.sv]
// Package: register offsets, field positions, reset values and state types
// for the buffer control/status register group.
// Assumes an 8-bit multiplexed microcontroller address/data bus.
package buf_regs_pkg;

    // ==========================================================
    // Register offsets on the microcontroller bus
    localparam logic [7:0] MISC_CONTROL_STATUS_OFS = 8'h4b;
    localparam logic [7:0] BUFFER_DATA_PORT_OFS = 8'h50;
    localparam logic [7:0] BUFFER_STATUS_CONTROL_OFS = 8'h51;

    // ==========================================================
    // Field positions
    localparam int REV_LSB = 0;           // Revision field, bits 3..0
    localparam int BURST_SEL_BIT = 4;     // DRAM burst length select
    localparam int OFFSET_LSB = 0;        // Running sync offset, bits 3..0
    localparam int FIFO_CLEAR_BIT = 4;    // FIFO clear
    localparam int ASYNC_SETUP_BIT = 5;   // async_setup_sel
    localparam int SYNC_SETUP_BIT = 6;    // Synchronous set-up select
    localparam int PULLUP_BIT = 7;        // Active pull-up enable

    // ==========================================================
    // Values after reset and fixed figures
    localparam logic BURST_SEL_RST = 1'b0;
    localparam logic [7:0] DATA_PORT_RST = 8'h00;
    localparam logic [3:0] STATUS_CTRL_RST = 4'h0;   // Control bits 7..4
    localparam logic [3:0] BURST_SHORT = 4'h4;
    localparam logic [3:0] BURST_LONG = 4'h8;
    localparam logic [2:0] ASYNC_SETUP_SHORT = 3'h1;  // Cycles of T
    localparam logic [2:0] ASYNC_SETUP_LONG = 3'h2;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ==========================================================
    // Buffer data port sequencer
    typedef enum logic [1:0] {
        PORT_IDLE,
        PORT_FETCH,
        PORT_STORE
    } port_state_t;

endpackage

// [design/pin_sync.sv]
// Three-stage synchroniser for a group of pins.
// Assumes each bit is independent; an output bit moves only when the
// second and third stages agree, so a single-stage glitch is ignored.
`timescale 1ns/10ps

module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] IDLE = '0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Pins in, filtered levels out
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out
);

    logic [W-1:0] stage1_q; // Metastable stage, read only by stage2
    logic [W-1:0] stage2_q;
    logic [W-1:0] stage3_q;
    logic [W-1:0] out_q;
    logic [W-1:0] agree;

    // ==========================================================
    // Shift chain
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stage1_q <= IDLE;
            stage2_q <= IDLE;
            stage3_q <= IDLE;
        end else begin
            stage1_q <= pin_in;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    assign agree = ~(stage2_q ^ stage3_q);

    // ==========================================================
    // Accept a change per bit only when stages two and three agree
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            out_q <= IDLE;
        end else begin
            out_q <= (stage3_q & agree) | (out_q & ~agree);
        end
    end

    assign pin_out = out_q;

endmodule // pin_sync

// [design/setup_timer.sv]
// Data set-up timer for the SCSI data path.
// Assumes the transfer engine pulses launch when new data is placed on
// the bus and waits for setup_done before asserting its strobe.
`timescale 1ns/10ps

module setup_timer
    import buf_regs_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Mode selection
    input wire logic sync_mode,
    input wire logic [3:0] sync_period,
    input wire logic async_sel,
    input wire logic sync_sel,
    // Launch and completion
    input wire logic launch,
    output logic setup_busy,
    output logic setup_done
);

    logic [4:0] count_q;  // Remaining set-up cycles
    logic busy_q;
    logic done_q;

    // Set-up length in system clock periods, never below one
    function automatic logic [4:0] setup_len(input logic smode, input logic [3:0] p,
                                             input logic asel, input logic ssel);
        logic [4:0] len;
        len = 5'h0;
        if (!smode) begin
            len = {2'b00, asel ? ASYNC_SETUP_LONG : ASYNC_SETUP_SHORT};
        end else if (p[0]) begin
            // Odd period: (P-1)/2 normally, (P+1)/2 when lengthened
            len = ssel ? 5'({1'b0, p} + 5'h1) >> 1 : 5'({1'b0, p} - 5'h1) >> 1;
        end else begin
            len = 5'({1'b0, p} >> 1);
        end
        if (len == 5'h0) begin
            len = 5'h1;
        end
        return len;
    endfunction

    // ==========================================================
    // Count the set-up window; a launch while busy restarts it
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            count_q <= 5'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (launch) begin
                count_q <= setup_len(sync_mode, sync_period, async_sel, sync_sel) - 5'h1;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (count_q == 5'h0) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    count_q <= count_q - 5'h1;
                end
            end
        end
    end

    assign setup_busy = busy_q;
    assign setup_done = done_q;

endmodule // setup_timer

// [design/buffer_ctrl_status_regs.sv]
// Buffer manager control/status registers on the microcontroller bus.
// Assumes the multiplexed address/data pins arrive asynchronously and the
// buffer memory arbiter, offset counter and host/buffer reset bit run on
// sys_clk.
`timescale 1ns/10ps

// Behaviour
// - Revision number reads in low four bits
// - Burst select chooses four or eight beats
// - Hardware reset clears burst select
// - Both buffer registers clear on either reset
// - Data port accesses memory at disk pointer
// - Drive-off makes port read configuration switches
// - Running synchronous offset reads in low nibble
// - FIFO clear bit empties the SCSI FIFO
// - Async set-up one or two clock periods
// - Bit seven enables SCSI active pull-ups
module buffer_ctrl_status_regs
    import buf_regs_pkg::*;
#(
    parameter int ADDR_W = 20,          // Buffer address width, 1 Mbyte
    parameter logic [3:0] CHIP_REV = 4'h1 // Arbitrary revision value
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Microcontroller multiplexed bus pins
    input wire logic cs_n,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] ad_in,
    output logic [7:0] ad_out,
    output logic ad_oe,
    // Buffer/host reset and drive-off controls from the neighbouring register
    input wire logic host_buf_reset,
    input wire logic memory_output_drive_off,
    // Buffer memory access
    input wire logic [ADDR_W-1:0] disk_addr_ptr,
    output logic mem_req,
    output logic mem_we,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata,
    output logic [3:0] dram_burst_beats,
    // SCSI data path
    input wire logic [3:0] sync_offset,
    output logic fifo_clear,
    output logic scsi_pullup_en,
    input wire logic sync_mode,
    input wire logic [3:0] sync_period,
    input wire logic data_launch,
    output logic setup_busy,
    output logic setup_done
);

    // ==========================================================
    // Pin synchronisation
    logic [11:0] pins_s;     // Filtered pin levels
    logic cs_n_s;
    logic ale_s;
    logic rd_n_s;
    logic wr_n_s;
    logic [7:0] ad_s;

    // Strobes idle high, ALE idles low, the data lines idle at zero
    pin_sync #(
        .W(12),
        .IDLE(12'hb00)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .pin_in({cs_n, ale, rd_n, wr_n, ad_in}),
        .pin_out(pins_s)
    );

    assign cs_n_s = pins_s[11];
    assign ale_s = pins_s[10];
    assign rd_n_s = pins_s[9];
    assign wr_n_s = pins_s[8];
    assign ad_s = pins_s[7:0];

    // ==========================================================
    // Bus cycle decode
    logic ale_prev_q;          // ALE level one cycle back
    logic rd_prev_q;           // Read active one cycle back
    logic wr_prev_q;           // Write active one cycle back
    logic [7:0] addr_q;        // Latched register address
    logic [7:0] wdata_q;       // Data captured while the write strobe is low
    logic rd_act;
    logic wr_act;
    logic rd_start;
    logic wr_end;

    assign rd_act = ~cs_n_s & ~rd_n_s;
    assign wr_act = ~cs_n_s & ~wr_n_s;
    assign rd_start = rd_act & ~rd_prev_q;
    // Writes take effect at the trailing edge, when the data is surely stable
    assign wr_end = wr_prev_q & ~wr_act;

    // Address selects, used by the write and read paths alike
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // History of the strobes for edge detection
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ale_prev_q <= 1'b0;
            rd_prev_q <= 1'b0;
            wr_prev_q <= 1'b0;
        end else begin
            ale_prev_q <= ale_s;
            rd_prev_q <= rd_act;
            wr_prev_q <= wr_act;
        end
    end

    // Address is taken on the falling edge of ALE
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            addr_q <= 8'h00;
        end else if (ale_prev_q && !ale_s) begin
            addr_q <= ad_s;
        end
    end

    // Write data follows the pins until the strobe rises
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wdata_q <= 8'h00;
        end else if (wr_act) begin
            wdata_q <= ad_s;
        end
    end

    // ==========================================================
    // Miscellaneous control/status: revision and burst select
    logic burst_sel_q;         // Set selects eight-beat bursts

    // Only the hardware reset clears this bit, not the host/buffer reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            burst_sel_q <= BURST_SEL_RST;
        end else if (wr_end && hit(addr_q, MISC_CONTROL_STATUS_OFS)) begin
            // Revision bits of the write are dropped here
            burst_sel_q <= wdata_q[BURST_SEL_BIT];
        end
    end

    assign dram_burst_beats = burst_sel_q ? BURST_LONG : BURST_SHORT;

    // ==========================================================
    // Buffer status/control: control bits 7..4
    logic fifo_clear_q;
    logic async_sel_q;
    logic sync_sel_q;
    logic pullup_q;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            {pullup_q, sync_sel_q, async_sel_q, fifo_clear_q} <= STATUS_CTRL_RST;
        end else if (host_buf_reset) begin
            {pullup_q, sync_sel_q, async_sel_q, fifo_clear_q} <= STATUS_CTRL_RST;
        end else if (wr_end && hit(addr_q, BUFFER_STATUS_CONTROL_OFS)) begin
            // Offset bits are read-only and ignored on write
            fifo_clear_q <= wdata_q[FIFO_CLEAR_BIT];
            async_sel_q <= wdata_q[ASYNC_SETUP_BIT];
            sync_sel_q <= wdata_q[SYNC_SETUP_BIT];
            pullup_q <= wdata_q[PULLUP_BIT];
        end
    end

    // The FIFO stays held empty for as long as the bit is set, so software
    // must drop it again before touching the FIFO
    assign fifo_clear = fifo_clear_q;
    assign scsi_pullup_en = pullup_q;

    // ==========================================================
    // Data set-up timing for the SCSI transfer engine
    setup_timer u_setup_timer (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .sync_mode(sync_mode),
        .sync_period(sync_period),
        .async_sel(async_sel_q),
        .sync_sel(sync_sel_q),
        .launch(data_launch),
        .setup_busy(setup_busy),
        .setup_done(setup_done)
    );

    // ==========================================================
    // Buffer data port and its memory sequencer
    port_state_t port_state_q;
    logic [7:0] data_port_q;       // Byte last written or fetched
    logic [ADDR_W-1:0] mem_addr_q;
    logic [7:0] mem_wdata_q;
    logic port_rd_start;
    logic port_wr_end;

    assign port_rd_start = rd_start & hit(addr_q, BUFFER_DATA_PORT_OFS);
    assign port_wr_end = wr_end & hit(addr_q, BUFFER_DATA_PORT_OFS);

    // Sequencer: one buffer cycle per port access, none for a read with drive-off set. A new access while one
    // is in flight is dropped; the microcontroller is far slower than the
    // arbiter, so this only bites if the arbiter stalls for long.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            port_state_q <= PORT_IDLE;
        end else if (host_buf_reset) begin
            port_state_q <= PORT_IDLE;
        end else begin
            case (port_state_q)
                PORT_IDLE: begin
                    if (port_wr_end) begin
                        port_state_q <= PORT_STORE;
                    end else if (port_rd_start && !memory_output_drive_off) begin
                        port_state_q <= PORT_FETCH;
                    end
                end
                PORT_FETCH, PORT_STORE: begin
                    // Held until the arbiter grants the cycle
                    if (mem_ack) begin
                        port_state_q <= PORT_IDLE;
                    end
                end
                default: begin
                    port_state_q <= PORT_IDLE;
                end
            endcase
        end
    end

    // Address and write data are frozen at the start of each cycle
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mem_addr_q <= '0;
            mem_wdata_q <= 8'h00;
        end else if (port_state_q == PORT_IDLE) begin
            if (port_wr_end) begin
                mem_addr_q <= disk_addr_ptr;
                mem_wdata_q <= wdata_q;
            end else if (port_rd_start) begin
                mem_addr_q <= disk_addr_ptr;
            end
        end
    end

    // Data port register: written value, fetched byte or switch values
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            data_port_q <= DATA_PORT_RST;
        end else if (host_buf_reset) begin
            data_port_q <= DATA_PORT_RST;
        end else if (port_wr_end && port_state_q == PORT_IDLE) begin
            data_port_q <= wdata_q;
        end else if (port_rd_start && memory_output_drive_off) begin
            // Memory drivers are off, so the bus shows the switch straps
            data_port_q <= mem_rdata;
        end else if (port_state_q == PORT_FETCH && mem_ack) begin
            data_port_q <= mem_rdata;
        end
    end

    assign mem_req = port_state_q != PORT_IDLE;
    assign mem_we = port_state_q == PORT_STORE;
    assign mem_addr = mem_addr_q;
    assign mem_wdata = mem_wdata_q;

    // ==========================================================
    // Read data path: refreshed every cycle so a fetched byte appears
    // on the pins while the read strobe is still low
    logic [7:0] rd_data_q;
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = UNMAPPED_READ;
        if (hit(addr_q, MISC_CONTROL_STATUS_OFS)) begin
            rd_mux = 8'h00;
            rd_mux[REV_LSB +: 4] = CHIP_REV;
            rd_mux[BURST_SEL_BIT] = burst_sel_q;
        end else if (hit(addr_q, BUFFER_DATA_PORT_OFS)) begin
            rd_mux = data_port_q;
        end else if (hit(addr_q, BUFFER_STATUS_CONTROL_OFS)) begin
            rd_mux[OFFSET_LSB +: 4] = sync_offset;
            rd_mux[FIFO_CLEAR_BIT] = fifo_clear_q;
            rd_mux[ASYNC_SETUP_BIT] = async_sel_q;
            rd_mux[SYNC_SETUP_BIT] = sync_sel_q;
            rd_mux[PULLUP_BIT] = pullup_q;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rd_data_q <= 8'h00;
        end else begin
            rd_data_q <= rd_mux;
        end
    end

    // Drive the pins only while a selected read strobe is seen low
    assign ad_out = rd_data_q;
    assign ad_oe = rd_act;

endmodule // buffer_ctrl_status_regs

// [test/buffer_ctrl_status_regs_assertions.sv]
// Checker for the buffer control/status register block.
// Sees only the top module ports; bound to every instance below.
`timescale 1ns/10ps

module buffer_ctrl_status_regs_assertions
    import buf_regs_pkg::*;
#(
    parameter int ADDR_W = 20
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Bus pins
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic ad_oe,
    // Memory side
    input wire logic [ADDR_W-1:0] disk_addr_ptr,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [3:0] dram_burst_beats,
    // Control outputs and set-up timer
    input wire logic host_buf_reset,
    input wire logic fifo_clear,
    input wire logic scsi_pullup_en,
    input wire logic sync_mode,
    input wire logic [3:0] sync_period,
    input wire logic data_launch,
    input wire logic setup_busy,
    input wire logic setup_done
);
    // ==========================================
    // Common clocking
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // ==========================================
    // Set-up launch steps
    sequence s_async_go;
        data_launch && !sync_mode && !setup_busy;
    endsequence
    sequence s_sync5_go;
        data_launch && sync_mode && sync_period == 4'h5 && !setup_busy;
    endsequence

    // ==========================================
    // Properties
    a_burst_values: assert property (dram_burst_beats == BURST_SHORT || dram_burst_beats == BURST_LONG)
        else $error("burst length is neither four nor eight");
    // Checked while reset is held, so the default disable is lifted
    a_reset_burst: assert property (disable iff (1'b0) !rstn |-> dram_burst_beats == BURST_SHORT)
        else $error("burst select not cleared by reset");
    a_hbr_clears: assert property (host_buf_reset |=> !fifo_clear && !scsi_pullup_en)
        else $error("host/buffer reset left control bits set");
    a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("memory request dropped or changed before ack");
    a_mem_end: assert property (mem_req && mem_ack |=> !mem_req)
        else $error("memory request outlived its ack");
    a_mem_addr: assert property ($rose(mem_req) |-> mem_addr == $past(disk_addr_ptr))
        else $error("memory address is not the disk pointer");
    a_oe_strobe: assert property ($rose(ad_oe) |-> !$past(rd_n, 2) && !$past(cs_n, 2))
        else $error("bus driven without a read strobe");
    a_done_pulse: assert property (setup_done |=> !setup_done)
        else $error("set-up done longer than one cycle");
    a_async_setup: assert property (s_async_go |-> ##[2:3] setup_done)
        else $error("async set-up not one or two periods");
    a_sync_setup: assert property (s_sync5_go |-> ##[3:4] setup_done)
        else $error("sync set-up for odd period is wrong");
endmodule // buffer_ctrl_status_regs_assertions

bind buffer_ctrl_status_regs buffer_ctrl_status_regs_assertions #(.ADDR_W(ADDR_W)) chk_i (
    .sys_clk, .rstn, .cs_n, .rd_n, .ad_oe, .disk_addr_ptr, .mem_req, .mem_we, .mem_addr,
    .mem_ack, .dram_burst_beats, .host_buf_reset, .fifo_clear, .scsi_pullup_en,
    .sync_mode, .sync_period, .data_launch, .setup_busy, .setup_done
);

// [test/mem_partner.sv]
// Behavioural buffer memory and arbiter facing the register block.
// Assumes one request at a time; answers promptly or after three waits.
`timescale 1ns/10ps

module mem_partner #(
    parameter int ADDR_W = 20,
    parameter logic [7:0] SWITCHES = 8'h5a // Configuration switch levels
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Requests from the block
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    // Bench controls
    input wire logic drive_off,
    input wire logic slow,
    // Answers
    output logic mem_ack,
    output logic [7:0] mem_rdata
);
    // ==========================================
    // Storage and wait counter
    logic [7:0] cells [256]; // Only the low address byte is decoded
    logic [1:0] wait_q; // Waits served so far
    logic [7:0] last_q; // Last byte on the bus

    // Grant after zero or three waits; ack is a one-cycle pulse
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mem_ack <= 1'b0;
            wait_q <= 2'h0;
            last_q <= 8'h00;
        end else if (mem_req && !mem_ack) begin
            if (wait_q == (slow ? 2'h3 : 2'h0)) begin
                mem_ack <= 1'b1;
                wait_q <= 2'h0;
                last_q <= mem_we ? mem_wdata : cells[mem_addr[7:0]];
                if (mem_we) begin
                    cells[mem_addr[7:0]] <= mem_wdata;
                end
            end else begin
                wait_q <= wait_q + 2'h1;
            end
        end else begin
            mem_ack <= 1'b0;
        end
    end

    // Outside ack, with drive-off low, the bus shows the inverse of its last byte, so a stale
    // value never passes by chance
    assign mem_rdata = drive_off ? SWITCHES : (mem_ack ? cells[mem_addr[7:0]] : ~last_q);
endmodule // mem_partner

// [test/buffer_ctrl_status_regs_tb.sv]
// Self-checking bench for the buffer control/status register block.
// Drives the multiplexed pins at the falling edge; memory is a partner model.
`timescale 1ns/10ps

module buffer_ctrl_status_regs_tb;
    import buf_regs_pkg::*;
    localparam logic [3:0] REV = 4'h3; // Arbitrary revision value
    localparam logic [7:0] SW = 8'h5a; // Switch levels
    localparam logic [19:0] CASES [4] = '{20'h05001, 20'h05202, 20'h15002, 20'h15403};
    // ==========================================
    // Signals
    logic sys_clk = 0, rstn = 1, cs_n = 1, ale = 0, rd_n = 1, wr_n = 1;
    logic [7:0] ad_in = 8'h00, ad_out, mem_wdata, mem_rdata;
    logic ad_oe, mem_req, mem_we, mem_ack, fifo_clear, scsi_pullup_en, setup_busy, setup_done;
    logic host_buf_reset = 0, drive_off = 0, sync_mode = 0, data_launch = 0, slow = 0;
    logic [19:0] disk_addr_ptr = '0, mem_addr;
    logic [3:0] dram_burst_beats, sync_offset = 4'h0, sync_period = 4'h5;
    logic [15:0] rnd = 16'h7d29; // LFSR state, seed 32041
    logic [15:0] exp_q [$]; // Mask and expected read byte
    int n_errors = 0, n_compared = 0, cycles = 0, i;
    event got_rd;

    buffer_ctrl_status_regs #(.CHIP_REV(REV)) dut (.sys_clk, .rstn, .cs_n, .ale, .rd_n,
        .wr_n, .ad_in, .ad_out, .ad_oe, .host_buf_reset,
        .memory_output_drive_off(drive_off), .disk_addr_ptr, .mem_req, .mem_we, .mem_addr,
        .mem_wdata, .mem_ack, .mem_rdata, .dram_burst_beats, .sync_offset, .fifo_clear,
        .scsi_pullup_en, .sync_mode, .sync_period, .data_launch, .setup_busy, .setup_done);
    mem_partner #(.SWITCHES(SW)) far (.sys_clk, .rstn, .mem_req, .mem_we, .mem_addr,
        .mem_wdata, .drive_off, .slow, .mem_ack, .mem_rdata);

    // ==========================================
    // Helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One pin state, held six cycles so the filter surely passes it
    task automatic pins(input logic a, c, r, w, input logic [7:0] d);
        @(negedge sys_clk);
        {ale, cs_n, rd_n, wr_n, ad_in} = {a, c, r, w, d};
        repeat (5) @(negedge sys_clk);
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        pins(1, 0, 1, 1, a);
        pins(0, 0, 1, 1, a);
        pins(0, 0, 1, 0, d);
        pins(0, 1, 1, 1, ~d);
    endtask
    // Read: wait for the bus to be driven, allow a slow memory cycle, then note
    task automatic bus_rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        pins(1, 0, 1, 1, a);
        pins(0, 0, 1, 1, a);
        pins(0, 0, 0, 1, ~a);
        for (int k = 0; k < 10 && ad_oe !== 1'b1; k++) @(negedge sys_clk);
        repeat (10) @(negedge sys_clk);
        chk({7'h0, ad_oe}, 8'h01);
        exp_q.push_back({m, e & m});
        ->got_rd;
        pins(0, 1, 1, 1, a);
    endtask
    // Launch one set-up window and count cycles to done
    task automatic setup_len(input logic [19:0] c);
        int n;
        bus_wr(BUFFER_STATUS_CONTROL_OFS, c[11:4]);
        @(negedge sys_clk);
        {sync_mode, sync_period, data_launch} = {c[16], c[15:12], 1'b1};
        @(negedge sys_clk);
        data_launch = 0;
        n = 1;
        while (setup_done !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        chk(8'(n), {4'h0, c[3:0]} + 8'h1);
    endtask
    task automatic end_of_test;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================
    // Clock, timeout and result watcher
    initial forever #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    always begin : watch
        logic [15:0] x;
        @(got_rd);
        x = exp_q.pop_front();
        chk(ad_out & x[15:8], x[7:0]);
    end

    // ==========================================
    // Main sequence
    initial begin
        #1 rstn = 0;
        repeat (10) @(negedge sys_clk);
        rstn = 1;
        repeat (2) @(negedge sys_clk);
        chk({4'h0, dram_burst_beats}, {4'h0, BURST_SHORT});
        chk({6'h0, fifo_clear, scsi_pullup_en}, 8'h00);
        bus_rd(MISC_CONTROL_STATUS_OFS, {4'h0, REV}, 8'h1f);
        bus_wr(MISC_CONTROL_STATUS_OFS, {4'h1, ~REV});
        chk({4'h0, dram_burst_beats}, {4'h0, BURST_LONG});
        bus_rd(MISC_CONTROL_STATUS_OFS, {4'h1, REV}, 8'h1f);
        // Every pairing of FIFO clear and pull-up, random other bits
        for (i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            sync_offset = rnd[11:8];
            bus_wr(BUFFER_STATUS_CONTROL_OFS, {i[0], rnd[6:5], i[1], rnd[3:0]});
            chk({7'h0, scsi_pullup_en}, {7'h0, i[0]});
            chk({7'h0, fifo_clear}, {7'h0, i[1]});
            bus_rd(BUFFER_STATUS_CONTROL_OFS, {i[0], rnd[6:5], i[1], rnd[11:8]}, 8'hff);
        end
        bus_wr(BUFFER_STATUS_CONTROL_OFS, 8'h00);
        // Data port through the disk pointer, prompt and slow memory
        for (i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            slow = i[0];
            disk_addr_ptr = {12'h000, rnd[7:0]};
            bus_wr(BUFFER_DATA_PORT_OFS, rnd[15:8]);
            bus_rd(BUFFER_DATA_PORT_OFS, rnd[15:8], 8'hff);
            chk(far.cells[rnd[7:0]], rnd[15:8]);
        end
        drive_off = 1;
        bus_rd(BUFFER_DATA_PORT_OFS, SW, 8'hff);
        drive_off = 0;
        // Host/buffer reset clears control bits, offset still reads
        bus_wr(BUFFER_STATUS_CONTROL_OFS, 8'hf0);
        host_buf_reset = 1;
        @(negedge sys_clk);
        host_buf_reset = 0;
        chk({6'h0, fifo_clear, scsi_pullup_en}, 8'h00);
        bus_rd(BUFFER_STATUS_CONTROL_OFS, {4'h0, sync_offset}, 8'hff);
        for (i = 0; i < 4; i++) setup_len(CASES[i]);
        // Second reset in mid-run drops the long burst
        rstn = 0;
        @(negedge sys_clk);
        chk({4'h0, dram_burst_beats}, {4'h0, BURST_SHORT});
        rstn = 1;
        repeat (3) @(negedge sys_clk);
        end_of_test();
    end
endmodule // buffer_ctrl_status_regs_tb
